// file: cpw_pkg.sv
`default_nettype none
package cpw_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_POWER_CTRL = 8'h87;
  localparam logic [7:0] IDX_CLOCK_SEL = 8'h8F;
  localparam logic [7:0] IDX_WAKE_MASK = 8'h9F;
  localparam logic [7:0] IDX_TIMED_B = 8'hC9;
  localparam logic [7:0] IDX_STATUS = 8'hD0;
  localparam int unsigned AXI_AW = 12;
  localparam int unsigned IDX_LSB = 2;

  // Power control bit positions
  localparam int unsigned PC_IDLE_BIT = 0;
  localparam int unsigned PC_STOP_BIT = 1;
  localparam int unsigned PC_SLEEP_BIT = 2;

  // Clock select field positions
  localparam int unsigned CS_SRC_LSB = 0;
  localparam int unsigned CS_SETTLE_LSB = 2;
  localparam int unsigned CS_DIV_LSB = 4;

  // Reset values
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [1:0] SETTLE_RST = 2'h3;
  localparam logic [3:0] DIV_RST = 4'h9;
  localparam logic [7:0] MASK_RST = 8'hFF;

  // Clock source codes
  localparam logic [1:0] SRC_FAST_A = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_FAST_B = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // Timed access keys and window length in system clocks
  localparam logic [7:0] TB_KEY1 = 8'hAA;
  localparam logic [7:0] TB_KEY2 = 8'h55;
  localparam logic [7:0] TB_CLOSE = 8'h00;
  localparam logic [8:0] TB_WINDOW = 9'h100;

  // Regulator settle lengths in slow oscillator cycles
  localparam logic [8:0] SETTLE_C0 = 9'h008;
  localparam logic [8:0] SETTLE_C1 = 9'h010;
  localparam logic [8:0] SETTLE_C2 = 9'h040;
  localparam logic [8:0] SETTLE_C3 = 9'h100;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Clock configuration carried to the clock tree
  typedef struct packed {
    logic [3:0] prediv;
    logic [1:0] settle;
    logic [1:0] src;
  } cpw_ckcfg_t;

  // Power modes
  typedef enum logic [2:0] {MODE_RUN, MODE_IDLE, MODE_STOP, MODE_SLEEP, MODE_SETTLE} cpw_mode_t;

endpackage
`default_nettype wire

// file: cpw_clock_power_wake.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module cpw_clock_power_wake (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [cpw_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [cpw_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SLOW_OSC_32K,
  input wire logic [7:0] WAKE_PINS,
  input wire logic [7:0] IRQ_ENABLED,
  input wire logic IRQ_PENDING,
  output var cpw_pkg::cpw_ckcfg_t CLK_CFG,
  output logic CPU_CLK_EN,
  output logic SYS_CLK_EN,
  output logic FAST_OSC_EN,
  output logic MAIN_REG_EN,
  output logic WAKE_VECTOR,
  output logic WAKE_RESUME
);
  import cpw_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  cpw_mode_t mode_r; // Current power mode
  cpw_mode_t mode_nxt; // Next power mode
  logic [7:0] mask_r; // Wake enable mask
  logic [1:0] src_r; // Raw source select
  logic [1:0] settle_r; // Settle delay code
  logic [3:0] prediv_r; // Fast oscillator predivider
  logic [8:0] tb_cnt_r; // Timed window cycles left
  logic tb_armed_r; // First key seen
  logic tb_open; // Window open
  logic [8:0] settle_cnt_r; // Slow ticks left in settle
  logic [8:0] settle_len; // Decoded settle length
  logic [2:0] slow_sync_r; // Slow oscillator sync and history
  logic slow_tick; // One pulse per slow rising edge
  logic [7:0] wake_s1_r; // Wake pin first stage
  logic [7:0] wake_s2_r; // Wake pin second stage
  logic [7:0] wake_old_r; // Wake pin history
  logic [7:0] wake_edge; // Rising edges seen
  logic [7:0] wake_hits; // Edges allowed by mask
  logic wake_hit; // Any allowed wake in stop or sleep
  logic [7:0] wake_src_r; // Sources of the last wake from stop or sleep
  logic [7:0] exit_src; // Sources behind the present exit
  logic [AXI_AW-1:0] aw_addr_r; // Latched write address
  logic aw_have_r; // Write address held
  logic [7:0] w_data_r; // Latched write byte
  logic w_lane_r; // Low byte lane enabled
  logic w_have_r; // Write data held
  logic wr_go; // Write performs this cycle
  logic [7:0] wr_idx; // Write register index
  logic wr_hit; // Write index is mapped
  logic pc_wr; // Power control write
  logic cs_wr; // Clock select write
  logic wm_wr; // Wake mask write
  logic tb_wr; // Timed access write
  logic [7:0] rd_idx; // Read register index
  logic [31:0] rd_data; // Read mux
  logic rd_hit; // Read index is mapped

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the core clock keeps running in every mode
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      slow_sync_r <= 3'h0;
    end else begin
      slow_sync_r <= {slow_sync_r[1:0], SLOW_OSC_32K};
    end
  end
  assign slow_tick = slow_sync_r[1] & ~slow_sync_r[2];

  // Wake pins: two stages, then a history stage for edge detection
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      wake_s1_r <= 8'h00;
      wake_s2_r <= 8'h00;
      wake_old_r <= 8'h00;
    end else begin
      wake_s1_r <= WAKE_PINS;
      wake_s2_r <= wake_s1_r;
      wake_old_r <= wake_s2_r;
    end
  end

  // Edge only, even where the interrupt itself is level triggered
  assign wake_edge = wake_s2_r & ~wake_old_r;
  assign wake_hits = wake_edge & mask_r;
  // Only pin-level sources reach here, so clocked peripherals never wake from stop or sleep
  assign wake_hit = (|wake_hits) && (mode_r == MODE_STOP || mode_r == MODE_SLEEP);
  assign exit_src = (mode_r == MODE_STOP) ? wake_hits : wake_src_r;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel; address and data accepted in either order
  assign wr_go = aw_have_r && w_have_r && !S_AXI_BVALID;
  assign wr_idx = aw_addr_r[IDX_LSB +: 8];
  assign wr_hit = (wr_idx == IDX_POWER_CTRL) || (wr_idx == IDX_CLOCK_SEL) ||
                  (wr_idx == IDX_WAKE_MASK) || (wr_idx == IDX_TIMED_B) || (wr_idx == IDX_STATUS);
  assign pc_wr = wr_go && w_lane_r && (wr_idx == IDX_POWER_CTRL);
  assign cs_wr = wr_go && w_lane_r && (wr_idx == IDX_CLOCK_SEL);
  assign wm_wr = wr_go && w_lane_r && (wr_idx == IDX_WAKE_MASK);
  assign tb_wr = wr_go && w_lane_r && (wr_idx == IDX_TIMED_B);

  // Address and data holding stages
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_have_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_r <= 1'b1;
        w_data_r <= S_AXI_WDATA[7:0];
        w_lane_r <= S_AXI_WSTRB[0];
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Ready flags and write response
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_have_r && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY <= !w_have_r && !(S_AXI_WVALID && S_AXI_WREADY);
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timed access window; a repeated key pair restarts the full window
  assign tb_open = (tb_cnt_r != 9'h000);
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      tb_cnt_r <= 9'h000;
      tb_armed_r <= 1'b0;
    end else if (tb_wr) begin
      tb_armed_r <= (w_data_r == TB_KEY1);
      if (tb_armed_r && w_data_r == TB_KEY2) begin
        tb_cnt_r <= TB_WINDOW;
      end else if (w_data_r == TB_CLOSE) begin
        tb_cnt_r <= 9'h000;
      end else if (tb_open) begin
        tb_cnt_r <= tb_cnt_r - 9'h001;
      end
    end else if (tb_open) begin
      tb_cnt_r <= tb_cnt_r - 9'h001;
    end
  end

  // Protected configuration; untouched by any mode change
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      src_r <= SRC_RST;
      settle_r <= SETTLE_RST;
      prediv_r <= DIV_RST;
    end else if (cs_wr && tb_open) begin
      src_r <= w_data_r[CS_SRC_LSB +: 2];
      settle_r <= w_data_r[CS_SETTLE_LSB +: 2];
      prediv_r <= w_data_r[CS_DIV_LSB +: 4];
    end
  end

  // Wake mask, also behind the timed window
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      mask_r <= MASK_RST;
    end else if (wm_wr && tb_open) begin
      mask_r <= w_data_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settle length decode
  always_comb begin
    case (settle_r)
      2'h0: settle_len = SETTLE_C0;
      2'h1: settle_len = SETTLE_C1;
      2'h2: settle_len = SETTLE_C2;
      default: settle_len = SETTLE_C3;
    endcase
  end

  // Power mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_RUN: begin
        if (pc_wr && w_data_r[PC_STOP_BIT] && w_data_r[PC_SLEEP_BIT]) begin
          mode_nxt = MODE_SLEEP;
        end else if (pc_wr && w_data_r[PC_STOP_BIT]) begin
          mode_nxt = MODE_STOP;
        end else if (pc_wr && w_data_r[PC_IDLE_BIT]) begin
          mode_nxt = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (IRQ_PENDING) begin
          mode_nxt = MODE_RUN;
        end
      end
      MODE_STOP: begin
        if (wake_hit) begin
          mode_nxt = MODE_RUN;
        end
      end
      MODE_SLEEP: begin
        if (wake_hit) begin
          mode_nxt = MODE_SETTLE;
        end
      end
      MODE_SETTLE: begin
        if (slow_tick && settle_cnt_r <= 9'h001) begin
          mode_nxt = MODE_RUN;
        end
      end
      default: mode_nxt = MODE_RUN;
    endcase
  end

  // Mode register; reset enters the settle wait too
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      mode_r <= MODE_SETTLE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Settle counter runs on slow ticks only
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      settle_cnt_r <= SETTLE_C3;
    end else if (mode_r == MODE_SLEEP && wake_hit) begin
      settle_cnt_r <= settle_len;
    end else if (mode_r == MODE_SETTLE && slow_tick && settle_cnt_r != 9'h000) begin
      settle_cnt_r <= settle_cnt_r - 9'h001;
    end
  end

  // Remember which sources ended sleep for the later exit
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      wake_src_r <= 8'h00;
    end else if (wake_hit) begin
      wake_src_r <= wake_hits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock tree and supply controls follow the next mode
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      CPU_CLK_EN <= 1'b0;
      SYS_CLK_EN <= 1'b0;
      FAST_OSC_EN <= 1'b1;
      MAIN_REG_EN <= 1'b1;
    end else begin
      CPU_CLK_EN <= (mode_nxt == MODE_RUN);
      SYS_CLK_EN <= (mode_nxt == MODE_RUN) || (mode_nxt == MODE_IDLE);
      // Dropped at the same edge that stops the clock, so no runt pulse
      FAST_OSC_EN <= !(mode_nxt == MODE_STOP || mode_nxt == MODE_SLEEP);
      MAIN_REG_EN <= (mode_nxt != MODE_SLEEP);
    end
  end

  // Configuration to the clock mux; 10 folds onto the fast code
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      CLK_CFG <= '{prediv: DIV_RST, settle: SETTLE_RST, src: SRC_RST};
    end else begin
      CLK_CFG.prediv <= prediv_r;
      CLK_CFG.settle <= settle_r;
      CLK_CFG.src <= (src_r == SRC_FAST_B) ? SRC_FAST_A : src_r;
    end
  end

  // Exit pulses: vector when the waking interrupt is enabled, else resume
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      WAKE_VECTOR <= 1'b0;
      WAKE_RESUME <= 1'b0;
    end else begin
      WAKE_VECTOR <= (mode_r == MODE_IDLE && mode_nxt == MODE_RUN) ||
                     (mode_r != MODE_IDLE && mode_r != MODE_RUN && mode_nxt == MODE_RUN &&
                      (|(exit_src & IRQ_ENABLED)));
      // A reset settle has no waking source, so it pulses neither line
      WAKE_RESUME <= (mode_r != MODE_IDLE && mode_r != MODE_RUN && mode_nxt == MODE_RUN &&
                      (|exit_src) && !(|(exit_src & IRQ_ENABLED)));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign rd_idx = S_AXI_ARADDR[IDX_LSB +: 8];
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    if (rd_idx == IDX_POWER_CTRL) begin
      rd_data[PC_IDLE_BIT] = (mode_r == MODE_IDLE);
      rd_data[PC_STOP_BIT] = (mode_r == MODE_STOP) || (mode_r == MODE_SLEEP);
      rd_data[PC_SLEEP_BIT] = (mode_r == MODE_SLEEP);
    end else if (rd_idx == IDX_CLOCK_SEL) begin
      // Settle code is write only
      rd_data[CS_SRC_LSB +: 2] = src_r;
      rd_data[CS_DIV_LSB +: 4] = prediv_r;
    end else if (rd_idx == IDX_WAKE_MASK) begin
      rd_data[7:0] = mask_r;
    end else if (rd_idx == IDX_TIMED_B) begin
      rd_data[0] = tb_open;
    end else if (rd_idx == IDX_STATUS) begin
      rd_data[2:0] = mode_r;
      rd_data[3] = tb_open;
      rd_data[15:8] = wake_src_r;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One read at a time; data registered on acceptance
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_data;
        S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  tb_open_a: assert property (tb_wr && tb_armed_r && w_data_r == TB_KEY2 |=> tb_cnt_r == TB_WINDOW)
    else $error("timed window did not open");
  cfg_guard_a: assert property ((cs_wr || wm_wr) && !tb_open |=> $stable(src_r) && $stable(mask_r))
    else $error("protected write outside window");
  stop_entry_a: assert property (mode_r == MODE_RUN && pc_wr && w_data_r[PC_STOP_BIT]
    && !w_data_r[PC_SLEEP_BIT] |=> mode_r == MODE_STOP && !FAST_OSC_EN && !SYS_CLK_EN)
    else $error("stop entry wrong");
  stop_wake_a: assert property (mode_r == MODE_STOP && wake_hit |=> CPU_CLK_EN && FAST_OSC_EN
    && (WAKE_VECTOR != WAKE_RESUME)) else $error("stop wake wrong");
  masked_wake_a: assert property (mode_r == MODE_STOP && (wake_edge & mask_r) == 8'h00
    |=> mode_r == MODE_STOP) else $error("masked source woke");
  sleep_reg_a: assert property (mode_r == MODE_SLEEP |-> !MAIN_REG_EN && !FAST_OSC_EN)
    else $error("regulator on in sleep");
  settle_hold_a: assert property (mode_r == MODE_SETTLE |-> !CPU_CLK_EN && !SYS_CLK_EN)
    else $error("clock during settle");
  settle_end_a: assert property (mode_r == MODE_SETTLE && slow_tick && settle_cnt_r == 9'h001
    |=> mode_r == MODE_RUN ##1 CPU_CLK_EN) else $error("settle end wrong");
  idle_exit_a: assert property (mode_r == MODE_IDLE && IRQ_PENDING |=> CPU_CLK_EN && WAKE_VECTOR)
    else $error("idle exit wrong");
  src_fold_a: assert property (src_r == SRC_FAST_B |=> CLK_CFG.src == SRC_FAST_A)
    else $error("source code not folded");
  resp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");

  sleep_cycle_c: cover property (mode_r == MODE_SLEEP ##[1:1000] mode_r == MODE_SETTLE);
  idle_cycle_c: cover property (mode_r == MODE_IDLE ##1 mode_r == MODE_RUN);
  stop_resume_c: cover property (mode_r == MODE_STOP ##1 WAKE_RESUME);
  cfg_write_c: cover property (cs_wr && tb_open);

endmodule // cpw_clock_power_wake
`default_nettype wire

// file: cpw_far_side.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Far side: slow oscillator and asynchronous wake sources
module cpw_far_side (
  input wire logic [7:0] wake_cmd,
  output logic slow_osc,
  output logic [7:0] wake_pins
);
  // Slow oscillator runs free, also in SLEEP; 170 ns keeps it unrelated to the core clock
  initial slow_osc = 1'b0;
  always #85 slow_osc = ~slow_osc;
  // Pins move off the core clock grid, so capture must be synchronised
  initial wake_pins = 8'h00;
  always @(wake_cmd) wake_pins <= #7 wake_cmd;
endmodule // cpw_far_side
`default_nettype wire

// file: clock_power_wake_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module clock_power_wake_ctrl_test;
  import cpw_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, irq_pend;
  logic awready, wready, bvalid, arready, rvalid, slow;
  logic [1:0] bresp, rresp;
  logic [7:0] irq_en, wake_cmd, pins, pv, mk;
  cpw_ckcfg_t cfg;
  logic cpu_en, sys_en, osc_en, reg_en, vec, res;
  logic [31:0] seed = 32'ha596_796a;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int t0;
  int settle_len [4] = '{8, 16, 64, 256};
  ////////////////////////////////////////////////////////////
  // 25 MHz core clock
  always #20 clk = ~clk;
  cpw_clock_power_wake cpw_clock_power_wake_i (.CORE_CLK(clk), .NRST(nrst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SLOW_OSC_32K(slow), .WAKE_PINS(pins), .IRQ_ENABLED(irq_en), .IRQ_PENDING(irq_pend),
    .CLK_CFG(cfg), .CPU_CLK_EN(cpu_en), .SYS_CLK_EN(sys_en), .FAST_OSC_EN(osc_en),
    .MAIN_REG_EN(reg_en), .WAKE_VECTOR(vec), .WAKE_RESUME(res));
  cpw_far_side cpw_far_side_i (.wake_cmd(wake_cmd), .slow_osc(slow), .wake_pins(pins));
  ////////////////////////////////////////////////////////////
  // Xorshift source for masks, dividers and interrupt enables
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard; the whole run needs about 3000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write: handshake sampled at the falling edge equals what the next rising edge sees
  task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bready && bvalid;
      r = bresp;
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    chk({30'h0, r}, {30'h0, er});
  endtask
  // Bus read with data and response check
  task rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic a, b;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      a = arvalid && arready;
      b = rready && rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (a) arvalid <= 1'b0;
      if (b) rready <= 1'b0;
    end
    chk(d, {24'h00_0000, ed});
    chk({30'h0, r}, {30'h0, er});
  endtask
  // Wait for the CPU clock, then check the one-cycle exit pulses beside it
  task wait_run(input logic [2:0] e);
    int n;
    n = 0;
    @(negedge clk);
    while (!cpu_en && n < 3000) begin
      n++;
      @(negedge clk);
    end
    chk({29'h0, cpu_en, vec, res}, {29'h0, e});
  endtask
  // Elapsed cycles against N slow periods of 170 ns, allowing sync and edge alignment
  task chk_settle(input int n);
    chk({31'h0, (cycles - t0 >= n * 17 / 4 - 8) && (cycles - t0 <= n * 17 / 4 + 10)}, 32'h1);
  endtask
  task drive_pins(input logic [7:0] v);
    @(posedge clk);
    wake_cmd <= v;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {irq_en, irq_pend, wake_cmd} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t0 = cycles;
    @(negedge clk);
    // Reset state: long settle, fast source, predivider code 9, full mask
    chk({24'h0, cfg}, {24'h0, DIV_RST, SETTLE_RST, SRC_RST});
    chk({28'h0, cpu_en, sys_en, osc_en, reg_en}, 32'h3);
    rd(IDX_CLOCK_SEL, 8'h90, RESP_OKAY);
    rd(IDX_WAKE_MASK, MASK_RST, RESP_OKAY);
    rd(IDX_STATUS, 8'h04, RESP_OKAY);
    wait_run(3'b100);
    chk_settle(256);
    $display("test reset done");
    // Protected writes need the key pair
    wr(IDX_CLOCK_SEL, 8'h51, RESP_OKAY);
    rd(IDX_CLOCK_SEL, 8'h90, RESP_OKAY);
    wr(IDX_TIMED_B, TB_KEY1, RESP_OKAY);
    wr(IDX_TIMED_B, TB_KEY2, RESP_OKAY);
    rd(IDX_TIMED_B, 8'h01, RESP_OKAY);
    pv = 8'(rnd());
    mk = (8'(rnd()) & 8'h7E) | 8'h80;
    // Every source code; ends on the fast source so STOP entry is clean
    for (int s = 3; s >= 0; s--) begin
      wr(IDX_CLOCK_SEL, {pv[3:0], 2'b00, 2'(s)}, RESP_OKAY);
      @(negedge clk);
      chk({24'h0, cfg}, {24'h0, pv[3:0], 2'b00, (s == 2) ? 2'b00 : 2'(s)});
    end
    wr(IDX_WAKE_MASK, mk, RESP_OKAY);
    rd(IDX_WAKE_MASK, mk, RESP_OKAY);
    wr(IDX_TIMED_B, TB_CLOSE, RESP_OKAY);
    wr(IDX_WAKE_MASK, 8'hFF, RESP_OKAY);
    rd(IDX_WAKE_MASK, mk, RESP_OKAY);
    rd(8'h10, 8'h00, RESP_SLVERR);
    wr(8'h10, 8'h00, RESP_SLVERR);
    $display("test window done");
    // STOP: masked pin must not wake, enabled pin must
    @(posedge clk);
    irq_en <= 8'(rnd());
    wr(IDX_POWER_CTRL, 8'h02, RESP_OKAY);
    @(negedge clk);
    chk({28'h0, cpu_en, sys_en, osc_en, reg_en}, 32'h1);
    drive_pins(8'h01);
    repeat (20) @(negedge clk);
    chk({31'h0, cpu_en}, 32'h0);
    drive_pins(8'h00);
    repeat (4) @(posedge clk);
    drive_pins(8'h80);
    wait_run({1'b1, irq_en[7], ~irq_en[7]});
    chk({24'h0, cfg}, {24'h0, pv[3:0], 4'h0});
    drive_pins(8'h00);
    rd(IDX_POWER_CTRL, 8'h00, RESP_OKAY);
    $display("test stop done");
    // SLEEP with every settle code
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      irq_en <= 8'(rnd());
      wr(IDX_TIMED_B, TB_KEY1, RESP_OKAY);
      wr(IDX_TIMED_B, TB_KEY2, RESP_OKAY);
      wr(IDX_CLOCK_SEL, {pv[3:0], 2'(k), 2'b00}, RESP_OKAY);
      wr(IDX_POWER_CTRL, 8'h06, RESP_OKAY);
      @(negedge clk);
      chk({28'h0, cpu_en, sys_en, osc_en, reg_en}, 32'h0);
      drive_pins(8'h80);
      t0 = cycles;
      wait_run({1'b1, irq_en[7], ~irq_en[7]});
      chk_settle(settle_len[k]);
      drive_pins(8'h00);
      rd(IDX_POWER_CTRL, 8'h00, RESP_OKAY);
    end
    $display("test sleep done");
    // IDLE: peripherals keep the system clock, only an interrupt ends it
    wr(IDX_POWER_CTRL, 8'h01, RESP_OKAY);
    @(negedge clk);
    chk({28'h0, cpu_en, sys_en, osc_en, reg_en}, 32'h7);
    rd(IDX_POWER_CTRL, 8'h01, RESP_OKAY);
    @(posedge clk);
    irq_pend <= 1'b1;
    wait_run(3'b110);
    @(posedge clk);
    irq_pend <= 1'b0;
    rd(IDX_POWER_CTRL, 8'h00, RESP_OKAY);
    $display("test idle done");
    report_and_stop;
  end
endmodule // clock_power_wake_ctrl_test
`default_nettype wire
